// >>> design/spi_dev_port.sv
// Operation
// - master drives select and clock; output released when deselected
// - clock idles low; sample rising, change falling
// - every byte travels most significant bit first
// - header top bit: 0 address, 1 command
// - header bottom bit 1 means read
// - master sends middle header bits as zero
// - status bytes shift out during header, address
// - bursts continue, address increments per data byte except at 0xff
// - address 0xff pops receive, pushes transmit queue
// - port works in every state, including sleep
// - event request appears on a configured pin
// - packet event flags at bits 0 to 11
// - signal quality flags at bits 12 to 14
// - device status flags 15-21, 29, 30
// - events set flags; reading status clears them
// - masked-off event raises no request
// - pin select code 0 gives active-low request
// - ready flag set on each ready entry
`include "spi_link_cfg.svh"

module spi_dev_port (
  input wire logic ref_clk_in, // system clock
  input wire logic rstn_in, // synchronous reset, active low
  spi_link_if.dev link_if, // serial link and gpio pins
  input wire logic [15:0] machine_state_bytes_in, // state bytes shifted out
  input wire logic [31:0] events_in, // one-cycle event pulses
  input wire logic [7:0] reg_rdata_in, // valid the cycle after reg_rd_out
  output logic [7:0] reg_addr_out, // register address
  output logic [7:0] reg_wdata_out, // register write data
  output logic reg_we_out, // register write pulse
  output logic reg_rd_out, // register read pulse
  input wire logic [7:0] rx_data_in, // receive queue head
  input wire logic rx_empty_in, // receive queue empty
  output logic rx_pop_out, // receive queue pop pulse
  input wire logic tx_full_in, // transmit queue full
  output logic tx_push_out, // transmit queue push pulse
  output logic [7:0] tx_data_out, // transmit queue data
  output logic [7:0] command_out, // command code
  output logic command_valid_out, // command execute pulse
  output logic event_request_low_out // unmasked event pending, low
);
  import spi_link_pkg::*;

  dev_state_s r;
  dev_state_s n;

  // returns {hit, lane} for a four-byte internal register
  function automatic logic [2:0] lane_hit(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    lane_hit = {d < `REG_LANES, d[1:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] fa;
    logic [2:0] hs;
    logic [2:0] hm;
    logic [2:0] hg;
    logic [31:0] clr;
    logic [31:0] err;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic do_fetch;
    byte_in = 8'h00;
    fa = r.addr;
    clr = 32'h0;
    err = 32'h0;
    do_fetch = 1'b0;
    hs = 3'h0;
    hm = 3'h0;
    hg = 3'h0;
    n = r;
    n.reg_we = 1'b0;
    n.reg_rd = 1'b0;
    n.rx_pop = 1'b0;
    n.tx_push = 1'b0;
    n.cmd_valid = 1'b0;
    n.rd_follow = r.reg_rd;
    n.cs_s1 = link_if.chip_select_low;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.sck_s1 = link_if.sclk;
    n.sck_s2 = r.sck_s1;
    n.sck_s3 = r.sck_s2;
    n.mosi_s1 = link_if.mosi;
    n.mosi_s2 = r.mosi_s1;
    sck_rise = r.sck_s2 & ~r.sck_s3;
    sck_fall = ~r.sck_s2 & r.sck_s3;
    cs_fall = ~r.cs_s2 & r.cs_s3;
    cs_rise = r.cs_s2 & ~r.cs_s3;
    n.miso_oe = ~r.cs_s2;
    // no power-state gating anywhere: the port answers in every state
    if (cs_rise) begin
      if (r.cmd_seen) begin
        n.cmd_valid = 1'b1;
        n.cmd_out = r.cmd_hold;
      end
      n.cmd_seen = 1'b0;
      n.stage = ST_HEADER;
      n.bit_cnt = 3'h0;
    end else if (cs_fall) begin
      // first bit must be on the line before the first rising edge
      n.stage = ST_HEADER;
      n.bit_cnt = 3'h0;
      n.miso = machine_state_bytes_in[15];
      n.tx_sh = {machine_state_bytes_in[14:8], 1'b0};
      n.tx_next = machine_state_bytes_in[7:0];
    end else if (~r.cs_s2) begin
      if (sck_rise) begin
        byte_in = {r.rx_sh[6:0], r.mosi_s2};
        n.rx_sh = byte_in;
        n.bit_cnt = r.bit_cnt + 3'h1;
        if (r.bit_cnt == `BIT_LAST) begin
          case (r.stage)
            ST_HEADER: begin
              n.is_cmd = byte_in[`HDR_CMD_BIT];
              n.is_rd = byte_in[`HDR_RD_BIT];
              n.stage = ST_ADDR;
            end
            ST_ADDR: begin
              n.stage = ST_DATA;
              n.tx_next = 8'h00;
              if (r.is_cmd) begin
                n.cmd_hold = byte_in;
                n.cmd_seen = 1'b1;
              end else begin
                n.addr = byte_in;
                fa = byte_in;
                do_fetch = r.is_rd;
              end
            end
            ST_DATA: begin
              // the queue address does not advance during a burst
              if (r.addr != `FIFO_ADDR) begin
                n.addr = r.addr + 8'h01;
              end
              fa = n.addr;
              if (!r.is_cmd && r.is_rd) begin
                do_fetch = 1'b1;
              end else if (!r.is_cmd) begin
                hm = lane_hit(r.addr, `MASK_BASE);
                hg = lane_hit(r.addr, `GPIO_BASE);
                hs = lane_hit(r.addr, `STAT_BASE);
                if (r.addr == `FIFO_ADDR) begin
                  if (tx_full_in) begin
                    err[`EVT_TXFIFO_ERR] = 1'b1;
                  end else begin
                    n.tx_push = 1'b1;
                    n.tx_data = byte_in;
                  end
                end else if (hm[2]) begin
                  n.mask[{hm[1:0], 3'b000} +: 8] = byte_in;
                end else if (hg[2]) begin
                  n.gpio_sel[hg[1:0]] = byte_in[4:0];
                end else if (!hs[2]) begin
                  n.reg_we = 1'b1;
                  n.reg_addr = r.addr;
                  n.reg_wdata = byte_in;
                end
              end
            end
            default: n.stage = ST_HEADER;
          endcase
        end
      end else if (sck_fall) begin
        if (r.bit_cnt == 3'h0) begin
          n.miso = r.tx_next[7];
          n.tx_sh = {r.tx_next[6:0], 1'b0};
        end else begin
          n.miso = r.tx_sh[7];
          n.tx_sh = {r.tx_sh[6:0], 1'b0};
        end
      end
    end
    if (r.rd_follow) begin
      n.tx_next = reg_rdata_in;
    end
    hm = lane_hit(fa, `MASK_BASE);
    hg = lane_hit(fa, `GPIO_BASE);
    hs = lane_hit(fa, `STAT_BASE);
    if (do_fetch) begin
      if (fa == `FIFO_ADDR) begin
        if (rx_empty_in) begin
          err[`EVT_RXFIFO_ERR] = 1'b1;
          n.tx_next = 8'h00;
        end else begin
          n.rx_pop = 1'b1;
          n.tx_next = rx_data_in;
        end
      end else if (hs[2]) begin
        n.tx_next = r.status[{hs[1:0], 3'b000} +: 8];
        clr[{hs[1:0], 3'b000} +: 8] = 8'hff;
      end else if (hm[2]) begin
        n.tx_next = r.mask[{hm[1:0], 3'b000} +: 8];
      end else if (hg[2]) begin
        n.tx_next = {3'h0, r.gpio_sel[hg[1:0]]};
      end else begin
        n.reg_rd = 1'b1;
        n.reg_addr = fa;
      end
    end
    // a new event in the clearing cycle survives the clear
    n.status = ((r.status & ~clr) | events_in | err) & `EVT_VALID;
    n.irq_low = ~|(r.status & r.mask);
    for (int i = 0; i < 4; i++) begin
      case (r.gpio_sel[i])
        `GPIO_SEL_IRQ: n.gpio[i] = r.irq_low;
        `GPIO_SEL_VDD: n.gpio[i] = 1'b1;
        `GPIO_SEL_GND: n.gpio[i] = 1'b0;
        default: n.gpio[i] = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      r <= '0;
      r.cs_s1 <= 1'b1;
      r.cs_s2 <= 1'b1;
      r.cs_s3 <= 1'b1;
      r.mask <= `MASK_RST;
      r.irq_low <= 1'b1;
      r.gpio <= `GPIO_OUT_RST;
    end else begin
      r <= n;
    end
  end

  assign link_if.miso = r.miso;
  assign link_if.miso_oe = r.miso_oe;
  assign link_if.gpio = r.gpio;
  assign reg_addr_out = r.reg_addr;
  assign reg_wdata_out = r.reg_wdata;
  assign reg_we_out = r.reg_we;
  assign reg_rd_out = r.reg_rd;
  assign rx_pop_out = r.rx_pop;
  assign tx_push_out = r.tx_push;
  assign tx_data_out = r.tx_data;
  assign command_out = r.cmd_out;
  assign command_valid_out = r.cmd_valid;
  assign event_request_low_out = r.irq_low;
endmodule

// >>> design/spi_host_ctrl.sv
`include "spi_link_cfg.svh"

module spi_host_ctrl #(
  parameter int SCLK_HALF_CYC = `SCLK_HALF_CYC,
  parameter int CS_SETUP_CYC = `CS_SETUP_CYC
) (
  input wire logic ref_clk_in, // system clock
  input wire logic rstn_in, // synchronous reset, active low
  spi_link_if.host link_if, // serial link and gpio pins
  input wire logic [7:0] wb_adr_in, // wishbone byte address
  input wire logic [31:0] wb_dat_in, // wishbone write data
  input wire logic [3:0] wb_sel_in, // wishbone byte enables
  input wire logic wb_we_in, // wishbone write
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out // wishbone acknowledge
);
  import spi_link_pkg::*;

  // 9-bit counters; 2*half*4ns must not beat the 10 MHz limit
  if (SCLK_HALF_CYC < 1 || SCLK_HALF_CYC > 511 ||
      2 * SCLK_HALF_CYC * `REF_CLK_NS < `SCLK_MIN_PERIOD_NS) begin
    $error("spi_host_ctrl: bad SCLK_HALF_CYC");
  end
  if (CS_SETUP_CYC < 1 || CS_SETUP_CYC > 511) begin
    $error("spi_host_ctrl: bad CS_SETUP_CYC");
  end

  host_state_s r;
  host_state_s n;

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    merge_sel = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge_sel[i * 8 +: 8] = nw[i * 8 +: 8];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] cmdw;
    logic [2:0] cnt_b;
    logic [47:0] txs;
    logic [5:0] shamt;
    logic take;
    logic half_done;
    cmdw = 32'h0;
    cnt_b = 3'h0;
    txs = 48'h0;
    shamt = {r.count, 3'b000};
    take = wb_cyc_in & wb_stb_in & ~r.ack;
    half_done = (r.cnt == 9'(SCLK_HALF_CYC - 1));
    n = r;
    n.ack = take;
    n.miso_s1 = link_if.miso_line;
    n.miso_s2 = r.miso_s1;
    n.gpio_s1 = link_if.gpio;
    n.gpio_s2 = r.gpio_s1;
    n.cnt = r.cnt + 9'h1;
    if (take && !wb_we_in) begin
      n.dat_out = 32'h0;
      case (wb_adr_in)
        `HREG_WDATA: n.dat_out = r.wdata;
        `HREG_RDATA: n.dat_out = r.rdata;
        `HREG_STAT: begin
          n.dat_out[`STAT_MS] = r.ms;
          n.dat_out[`STAT_GPIO] = r.gpio_s2;
          n.dat_out[`STAT_BUSY] = (r.phase != H_IDLE);
        end
        default: n.dat_out = 32'h0;
      endcase
    end
    if (take && wb_we_in && wb_adr_in == `HREG_WDATA) begin
      n.wdata = merge_sel(r.wdata, wb_dat_in, wb_sel_in);
    end
    case (r.phase)
      H_IDLE: begin
        n.cnt = 9'h0;
        // a start while busy is dropped; software polls the busy bit
        if (take && wb_we_in && wb_adr_in == `HREG_CMD) begin
          cmdw = merge_sel(32'h0, wb_dat_in, wb_sel_in);
          cnt_b = cmdw[`CMD_CNT];
          if (cmdw[`CMD_IS_CMD]) begin
            cnt_b = 3'h0;
          end else if (cnt_b > `MAX_DATA) begin
            cnt_b = `MAX_DATA;
          end
          // middle header bits forced to zero
          txs = {cmdw[`CMD_IS_CMD], 6'h00, cmdw[`CMD_RD], cmdw[`CMD_ADDR], r.wdata};
          n.count = cnt_b;
          n.total = `HDR_BITS + {cnt_b, 3'b000};
          n.bits = 6'h0;
          n.cs_low = 1'b0;
          n.mosi = txs[47];
          n.tx = {txs[46:0], 1'b0};
          n.phase = H_SETUP;
        end
      end
      H_SETUP: begin
        if (r.cnt == 9'(CS_SETUP_CYC - 1)) begin
          n.sclk = 1'b1;
          n.rx = {r.rx[46:0], r.miso_s2};
          n.bits = r.bits + 6'h1;
          n.cnt = 9'h0;
          n.phase = H_HIGH;
        end
      end
      H_LOW: begin
        if (half_done) begin
          n.sclk = 1'b1;
          n.rx = {r.rx[46:0], r.miso_s2};
          n.bits = r.bits + 6'h1;
          n.cnt = 9'h0;
          n.phase = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          n.sclk = 1'b0;
          n.cnt = 9'h0;
          if (r.bits == r.total) begin
            n.phase = H_END;
          end else begin
            n.mosi = r.tx[47];
            n.tx = {r.tx[46:0], 1'b0};
            n.phase = H_LOW;
          end
        end
      end
      H_END: begin
        if (half_done) begin
          n.cs_low = 1'b1;
          n.cnt = 9'h0;
          n.ms = 16'(r.rx >> shamt);
          n.rdata = 32'(r.rx & ~(`RX_ALL_ONES << shamt));
          n.phase = H_GAP;
        end
      end
      H_GAP: begin
        if (half_done) begin
          n.phase = H_IDLE;
        end
      end
      default: n.phase = H_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      r <= '0;
      r.cs_low <= 1'b1;
      r.miso_s1 <= 1'b1;
      r.miso_s2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link_if.chip_select_low = r.cs_low;
  assign link_if.sclk = r.sclk;
  assign link_if.mosi = r.mosi;
  assign wb_dat_out = r.dat_out;
  assign wb_ack_out = r.ack;
endmodule

// >>> design/spi_link_cfg.svh
`ifndef SPI_LINK_CFG_SVH
`define SPI_LINK_CFG_SVH

// clock and link timing
`define REF_CLK_NS 4
`define SCLK_MIN_PERIOD_NS 100
`define SCLK_HALF_NS 63
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define CS_SETUP_NS 2000
`define CS_SETUP_CYC ((`CS_SETUP_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

// frame layout
`define HDR_CMD_BIT 7
`define HDR_RD_BIT 0
`define BIT_LAST 3'h7
`define FIFO_ADDR 8'hff

// device-side internal registers, four byte lanes each, lane 0 = bits 7:0
`define REG_LANES 8'h04
`define GPIO_BASE 8'h01
`define MASK_BASE 8'h90
`define STAT_BASE 8'hfa
`define EVT_VALID 32'h603fffff
`define EVT_TXFIFO_ERR 5
`define EVT_RXFIFO_ERR 6
`define MASK_RST 32'h00000000
`define GPIO_OUT_RST 4'hf
`define GPIO_SEL_IRQ 5'h00
`define GPIO_SEL_VDD 5'h13
`define GPIO_SEL_GND 5'h14

// controller registers on the wishbone side
`define HREG_CMD 8'h00
`define HREG_WDATA 8'h04
`define HREG_RDATA 8'h08
`define HREG_STAT 8'h0c
`define CMD_RD 0
`define CMD_IS_CMD 1
`define CMD_ADDR 15:8
`define CMD_CNT 18:16
`define MAX_DATA 3'h4
`define HDR_BITS 6'h10
`define STAT_MS 15:0
`define STAT_GPIO 19:16
`define STAT_BUSY 31
`define RX_ALL_ONES 48'hffffffffffff

`endif

// >>> design/spi_link_if.sv
interface spi_link_if;
  logic chip_select_low;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  logic [3:0] gpio;

  // released line reads high, as through a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev (input chip_select_low, input sclk, input mosi, output miso, output miso_oe, output gpio);
  modport host (output chip_select_low, output sclk, output mosi, input miso_line, input gpio);
endinterface

// >>> design/spi_link_pkg.sv
package spi_link_pkg;

  typedef enum logic [1:0] {ST_HEADER, ST_ADDR, ST_DATA} dev_stage_e;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP} host_phase_e;

  typedef struct packed {
    logic cs_s1, cs_s2, cs_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic mosi_s1, mosi_s2;
    dev_stage_e stage;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh, tx_sh, tx_next;
    logic is_cmd, is_rd, cmd_seen, rd_follow;
    logic [7:0] addr, cmd_hold;
    logic [31:0] status, mask;
    logic [3:0][4:0] gpio_sel;
    logic irq_low, miso, miso_oe;
    logic [3:0] gpio;
    logic [7:0] reg_addr, reg_wdata;
    logic reg_we, reg_rd, rx_pop, tx_push;
    logic [7:0] tx_data, cmd_out;
    logic cmd_valid;
  } dev_state_s;

  typedef struct packed {
    host_phase_e phase;
    logic [8:0] cnt;
    logic [5:0] bits, total;
    logic [2:0] count;
    logic [47:0] tx, rx;
    logic miso_s1, miso_s2;
    logic [3:0] gpio_s1, gpio_s2;
    logic cs_low, sclk, mosi;
    logic ack;
    logic [31:0] dat_out, wdata, rdata;
    logic [15:0] ms;
  } host_state_s;

endpackage

// >>> verif/spi_host_port_with_irq_asserts.sv
module spi_host_port_with_irq_asserts #(
  parameter int CS_SETUP_CYC = 20
) (
  input wire logic ref_clk_in, // system clock
  input wire logic rstn_in, // sync reset, low
  input wire logic chip_select_low, // select, low active
  input wire logic sclk, // bit clock
  input wire logic mosi, // host data
  input wire logic miso, // device data
  input wire logic miso_oe, // device drives line
  input wire logic miso_line, // resolved line
  input wire logic [3:0] gpio // device pins
);
  logic [15:0] setup_cnt_reg;
  logic [2:0] rise_cnt_reg;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////
  // counts cycles of select low and clock rises within a frame
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in || chip_select_low) begin
      setup_cnt_reg <= 16'h0000;
      rise_cnt_reg <= 3'h0;
    end else begin
      if (setup_cnt_reg != 16'hffff) setup_cnt_reg <= setup_cnt_reg + 16'h0001;
      if ($rose(sclk)) rise_cnt_reg <= rise_cnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // device sees select through three flops, so allow the lag
  a_release_when_idle: assert property (chip_select_low [*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_drive_needs_select: assert property ($rose(miso_oe) |-> !$past(chip_select_low, 2))
    else $error("miso driven without select");
  a_clock_only_selected: assert property ($rose(sclk) |-> !chip_select_low)
    else $error("clock edge outside frame");
  a_setup_before_clock: assert property ($rose(sclk) |-> setup_cnt_reg >= CS_SETUP_CYC - 1)
    else $error("clock too soon after select");
  a_clock_idle_low: assert property (chip_select_low |-> !sclk)
    else $error("clock not low while idle");
  a_mosi_stable_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi changed while clock high");
  a_miso_stable_rise: assert property ($rose(sclk) && miso_oe && $past(miso_oe) |-> $stable(miso))
    else $error("miso changed at rising edge");
  a_clock_half_period: assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high phase too short");
  a_whole_bytes: assert property ($rose(chip_select_low) |-> rise_cnt_reg == 3'h0)
    else $error("frame not whole bytes");

  cover property ($rose(miso_oe));
  cover property ($rose(chip_select_low) && miso_line);
  cover property ($fell(gpio[0]));
endmodule

// >>> verif/spi_host_port_with_irq_tb_top.sv
`include "spi_link_cfg.svh"

module spi_host_port_with_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_link_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_rdata, wb_q;
  logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_ack;
  logic [15:0] ms = 16'h0000;
  logic [31:0] events = 32'h0;
  logic [7:0] reg_rdata = 8'h00, rx_data = 8'h00;
  logic rx_empty = 1'b1, tx_full = 1'b0;
  logic [7:0] reg_addr, reg_wdata, tx_data, cmd_code, cmd_got;
  logic reg_we, reg_rd, rx_pop, tx_push, cmd_valid, req_low;
  logic [7:0] ext_mem [256];
  logic [7:0] rxq[$], txq[$];
  int cmd_cnt = 0, errors = 0, comparisons = 0, cycles = 0;

  spi_link_if link_if ();
  spi_dev_port i_spi_dev_port (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link_if(link_if),
    .machine_state_bytes_in(ms), .events_in(events), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_we_out(reg_we), .reg_rd_out(reg_rd), .rx_data_in(rx_data),
    .rx_empty_in(rx_empty), .rx_pop_out(rx_pop), .tx_full_in(tx_full), .tx_push_out(tx_push),
    .tx_data_out(tx_data), .command_out(cmd_code), .command_valid_out(cmd_valid),
    .event_request_low_out(req_low));
  spi_host_ctrl #(.SCLK_HALF_CYC(16), .CS_SETUP_CYC(20)) i_spi_host_ctrl (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .link_if(link_if), .wb_adr_in(wb_adr), .wb_dat_in(wb_dat), .wb_sel_in(4'hf),
    .wb_we_in(wb_we), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_dat_out(wb_rdata), .wb_ack_out(wb_ack));
  spi_host_port_with_irq_asserts #(.CS_SETUP_CYC(20)) i_spi_host_port_with_irq_asserts (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .chip_select_low(link_if.chip_select_low),
    .sclk(link_if.sclk), .mosi(link_if.mosi), .miso(link_if.miso), .miso_oe(link_if.miso_oe),
    .miso_line(link_if.miso_line), .gpio(link_if.gpio));

  initial forever #2 ref_clk_in = ~ref_clk_in;

  ////////////////////////////////////////////////////////////////
  // far side of the device: registers, queues, command sink
  always @(posedge ref_clk_in) begin
    cycles++;
    if (reg_rd === 1'b1) reg_rdata <= ext_mem[reg_addr];
    if (reg_we === 1'b1) ext_mem[reg_addr] = reg_wdata;
    if (tx_push === 1'b1) txq.push_back(tx_data);
    if (cmd_valid === 1'b1) begin
      cmd_got = cmd_code;
      cmd_cnt++;
    end
    if (rx_pop === 1'b1 && rxq.size() > 0) void'(rxq.pop_front());
    rx_data <= (rxq.size() > 0) ? rxq[0] : 8'h00;
    rx_empty <= (rxq.size() == 0);
    if (cycles == 60000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // byte lanes reversed: first byte on the wire lands highest
  function automatic logic [31:0] lanes(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge ref_clk_in);
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge ref_clk_in); while (wb_ack !== 1'b1);
    wb_q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // one frame: load data, start, poll busy, fetch received bytes
  task automatic xfer(input logic cmd, input logic rd, input logic [7:0] a, input logic [2:0] n,
                      input logic [31:0] wd);
    int k;
    logic [15:0] s;
    s = 16'($urandom);
    ms <= s;
    wb_cycle(`HREG_WDATA, 1'b1, wd);
    wb_cycle(`HREG_CMD, 1'b1, {13'h0000, n, a, 6'h00, cmd, rd});
    k = 0;
    do begin
      wb_cycle(`HREG_STAT, 1'b0, 32'h0);
      k++;
    end while (wb_q[`STAT_BUSY] !== 1'b0 && k < 5000);
    chk_flag("frame done", 1'b0, wb_q[`STAT_BUSY]);
    chk_val("state bytes", {16'h0000, s}, {16'h0000, wb_q[`STAT_MS]});
    wb_cycle(`HREG_RDATA, 1'b0, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] wd, m, p;
    logic [7:0] b [4];
    int k0;
    void'($urandom(42));
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    wb_cycle(8'h10, 1'b0, 32'h0);
    chk_val("unmapped read", 32'h0, wb_q);
    wd = $urandom;
    xfer(1'b0, 1'b0, 8'h20, 3'h4, wd);
    for (int i = 0; i < 4; i++) chk_val("ext byte", {24'h0, wd[31-8*i -: 8]}, {24'h0, ext_mem[8'h20+i]});
    xfer(1'b0, 1'b1, 8'h20, 3'h4, 32'h0);
    chk_val("burst read", wd, wb_q);
    xfer(1'b0, 1'b1, 8'h21, 3'h2, 32'h0);
    chk_val("short read", {16'h0000, wd[23:8]}, wb_q);
    txq.delete();
    wd = $urandom;
    xfer(1'b0, 1'b0, `FIFO_ADDR, 3'h3, wd);
    chk_val("tx count", 32'h3, 32'(txq.size()));
    for (int i = 0; i < 3; i++) chk_val("tx byte", {24'h0, wd[31-8*i -: 8]}, {24'h0, txq[i]});
    tx_full <= 1'b1;
    xfer(1'b0, 1'b0, `FIFO_ADDR, 3'h1, wd);
    tx_full <= 1'b0;
    xfer(1'b0, 1'b1, `STAT_BASE, 3'h1, 32'h0);
    chk_flag("tx queue error", 1'b1, wb_q[`EVT_TXFIFO_ERR]);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      rxq.push_back(b[i]);
    end
    xfer(1'b0, 1'b1, `FIFO_ADDR, 3'h2, 32'h0);
    chk_val("rx pop", {16'h0000, b[0], b[1]}, wb_q);
    rxq.delete();
    xfer(1'b0, 1'b1, `FIFO_ADDR, 3'h1, 32'h0);
    chk_val("empty pop", 32'h0, wb_q);
    xfer(1'b0, 1'b1, `STAT_BASE, 3'h1, 32'h0);
    chk_flag("rx queue error", 1'b1, wb_q[`EVT_RXFIFO_ERR]);
    wd = $urandom;
    k0 = cmd_cnt;
    xfer(1'b1, 1'b0, wd[7:0], 3'h0, 32'h0);
    repeat (8) @(posedge ref_clk_in);
    chk_val("command count", 32'(k0 + 1), 32'(cmd_cnt));
    chk_val("command code", {24'h0, wd[7:0]}, {24'h0, cmd_got});
    xfer(1'b0, 1'b1, `STAT_BASE, 3'h4, 32'h0);
    // pin 0 request, pin 1 high, pin 2 low, pin 3 unused code reads low
    wd = {8'h00, 3'h0, `GPIO_SEL_VDD, 3'h0, `GPIO_SEL_GND, 8'h05};
    xfer(1'b0, 1'b0, `GPIO_BASE, 3'h4, wd);
    chk_val("gpio pins", 32'h3, {28'h0, link_if.gpio});
    xfer(1'b0, 1'b1, `GPIO_BASE, 3'h4, 32'h0);
    chk_val("gpio select", wd, wb_q);
    wb_cycle(`HREG_STAT, 1'b0, 32'h0);
    chk_val("gpio status", 32'h3, {28'h0, wb_q[`STAT_GPIO]});
    // first round masks all, last round raises every event
    for (int r = 0; r < 4; r++) begin
      m = (r == 0) ? 32'h0 : $urandom;
      p = (r == 3) ? 32'hffffffff : $urandom;
      xfer(1'b0, 1'b0, `MASK_BASE, 3'h4, lanes(m));
      xfer(1'b0, 1'b1, `MASK_BASE, 3'h4, 32'h0);
      chk_val("mask", lanes(m), wb_q);
      events <= p;
      @(posedge ref_clk_in);
      events <= 32'h0;
      repeat (4) @(posedge ref_clk_in);
      chk_flag("request", ((p & `EVT_VALID & m) == 32'h0), req_low);
      chk_flag("gpio request", ((p & `EVT_VALID & m) == 32'h0), link_if.gpio[0]);
      xfer(1'b0, 1'b1, `STAT_BASE, 3'h4, 32'h0);
      chk_val("status", lanes(p & `EVT_VALID), wb_q);
      xfer(1'b0, 1'b1, `STAT_BASE, 3'h4, 32'h0);
      chk_val("status cleared", 32'h0, wb_q);
      chk_flag("request released", 1'b1, req_low);
    end
    stop_test();
  end
endmodule
